// ==== flk_pkg.sv ====
// Purpose: shared constants and types of the flash lock and identification register set
// Assumes: byte wide register cycles, 28-bit memory addresses, 20 MHz clock
// Notes: lock register of block b sits at the lock base with b in address bits 19:16
package flk_pkg;

  localparam int FLK_NUM_BLOCKS = 16;
  localparam logic [3:0] FLK_TOP_BLOCK = 4'hf;
  localparam int FLK_GPI_W = 5;

  localparam logic [27:0] FLK_LOCK_BASE = 28'hfb00002;
  localparam logic [27:0] FLK_LOCK_MASK = 28'hff0ffff;
  localparam int FLK_LOCK_BLK_LSB = 16;
  localparam logic [27:0] FLK_GPI_ADDR = 28'hfbc0100;
  localparam logic [27:0] FLK_MAKER_ADDR = 28'hfbc0000;
  localparam logic [27:0] FLK_PART_ADDR = 28'hfbc0001;

  localparam int FLK_BIT_WRITE_PROT = 0;
  localparam int FLK_BIT_FREEZE = 1;
  localparam int FLK_BIT_READ_PROT = 2;
  localparam int FLK_STAT_PROT_BIT = 1;
  localparam int FLK_STAT_READY_BIT = 7;

  localparam logic [7:0] FLK_READ_LOCKED_DATA = 8'h00;
  localparam logic [7:0] FLK_UNMAPPED_DATA = 8'h00;

  localparam int FLK_CLK_MHZ = 20;
  localparam int FLK_PROG_PAUSE_US = 5;
  localparam int FLK_ERASE_PAUSE_US = 30;
  localparam logic [9:0] FLK_PROG_PAUSE_CYC = 10'(FLK_PROG_PAUSE_US * FLK_CLK_MHZ);
  localparam logic [9:0] FLK_ERASE_PAUSE_CYC = 10'(FLK_ERASE_PAUSE_US * FLK_CLK_MHZ);

  typedef struct packed {
    logic read_prot;
    logic freeze;
    logic write_prot;
  } flk_lock_type;

  localparam flk_lock_type FLK_LOCK_RESET = 3'b001;

endpackage : flk_pkg

// ==== flk_lock_cell.sv ====
// Purpose: one per-block lock register with read protect, freeze and write protect
// Assumes: soft_rst is a synchronous clear from the interface or processor reset pins
// Notes: the freeze bit can only be left by a reset of some kind
`timescale 1ns/1ps
`default_nettype none
module flk_lock_cell
  import flk_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic soft_rst,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  output flk_lock_type lock
);

  flk_lock_type lock_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lock_q <= FLK_LOCK_RESET;
    end else if (soft_rst) begin
      lock_q <= FLK_LOCK_RESET;
    end else if (wr_en && !lock_q.freeze) begin
      // reserved bits 7:3 of wdata are simply dropped
      lock_q.read_prot <= wdata[FLK_BIT_READ_PROT];
      lock_q.freeze <= wdata[FLK_BIT_FREEZE];
      lock_q.write_prot <= wdata[FLK_BIT_WRITE_PROT];
    end
  end

  assign lock = lock_q;

  property p_frozen_holds;
    @(posedge clk) disable iff (!nrst)
    (lock_q.freeze && !soft_rst) |=> (lock_q == $past(lock_q));
  endproperty
  a_frozen_holds: assert property (p_frozen_holds) else $error("frozen lock register changed");

  property p_freeze_sticky;
    @(posedge clk) disable iff (!nrst)
    ($past(lock_q.freeze) && !$past(soft_rst)) |-> lock_q.freeze;
  endproperty
  a_freeze_sticky: assert property (p_freeze_sticky) else $error("freeze bit cleared by a write");

  property p_soft_reset;
    @(posedge clk) disable iff (!nrst)
    soft_rst |=> (lock_q == FLK_LOCK_RESET);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("pin reset did not restore lock default");

  c_freeze_set: cover property (@(posedge clk) disable iff (!nrst) $rose(lock_q.freeze));

endmodule : flk_lock_cell
`default_nettype wire

// ==== flk_pause_timer.sv ====
// Purpose: bounds the time from a suspend request to the pause of a program or erase
// Assumes: the controller marks safe points where it can pause early
// Notes: the limit is a hard deadline, the pause is forced even without a safe point
`timescale 1ns/1ps
`default_nettype none
module flk_pause_timer
  import flk_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic susp_req,
  input wire logic op_active,
  input wire logic op_is_erase,
  input wire logic safe_point,
  output logic pause
);

  logic run_q;
  logic [9:0] cnt_q;
  logic [9:0] limit_q;

  assign pause = run_q && op_active && (safe_point || cnt_q >= limit_q);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_q <= 1'b0;
    end else if (pause || !op_active) begin
      run_q <= 1'b0;
    end else if (susp_req) begin
      run_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 10'h000;
      limit_q <= FLK_PROG_PAUSE_CYC;
    end else if (susp_req && op_active && !run_q) begin
      cnt_q <= 10'h001;
      limit_q <= op_is_erase ? FLK_ERASE_PAUSE_CYC : FLK_PROG_PAUSE_CYC;
    end else if (run_q) begin
      cnt_q <= cnt_q + 10'h001;
    end
  end

  property p_prog_pause;
    @(posedge clk) disable iff (!nrst)
    (susp_req && op_active && !run_q && !op_is_erase) |-> ##[1:100] (pause || !op_active);
  endproperty
  a_prog_pause: assert property (p_prog_pause) else $error("program pause too late");

  property p_erase_pause;
    @(posedge clk) disable iff (!nrst)
    (susp_req && op_active && !run_q && op_is_erase) |-> ##[1:600] (pause || !op_active);
  endproperty
  a_erase_pause: assert property (p_erase_pause) else $error("erase pause too late");

  c_forced_pause: cover property (@(posedge clk) disable iff (!nrst) pause && !safe_point);

endmodule : flk_pause_timer
`default_nettype wire

// ==== flk_regs.sv ====
// Purpose: lock, general purpose input and identification registers with array protection gating
// Assumes: one array read outstanding at a time; all pins synchronous to CLK
// Notes: the reset pins act synchronously, NRST is the power-up reset
//
// Function
// - reading the input snapshot returns the live pin levels; writes ignored.
// - snapshot bits 4:0 are inputs 4:0, one means high, 7:5 reserved.
// - maker identifier register returns a fixed code and ignores writes.
// - part identifier register returns a fixed code and ignores writes.
// - read protect set makes every array read of that block return zero.
// - read protect clear passes array data; clear is the reset default.
// - while freeze is set, writes cannot change the protect bits.
// - once freeze is written to one, writes cannot clear it.
// - freeze clears on interface reset, processor reset or power-up.
// - write protect set makes program and erase fail with a status error.
// - write protect defaults to one; when zero, program and erase proceed.
// - lock bits 7:3 reserved; same layout for all sixteen block registers.
// - a suspend pauses a running program within five microseconds.
// - a suspend pauses a running block erase within thirty microseconds.
// - a protection reject sets status bits one and seven.
// - low top guard pin protects block 15; low write guard protects 0 to 14.
`timescale 1ns/1ps
`default_nettype none
module flk_regs
  import flk_pkg::*;
#(
  // value is arbitrary
  parameter logic [7:0] MAKER_CODE = 8'h5a,
  // value is arbitrary
  parameter logic [7:0] PART_CODE = 8'ha5
)
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic INTERFACE_RESET_PIN_N,
  input wire logic CPU_RESET_PIN_N,
  input wire logic [FLK_GPI_W-1:0] GENERAL_PURPOSE_INPUTS,
  input wire logic TOP_BLOCK_GUARD_PIN_N,
  input wire logic WRITE_GUARD_PIN_N,
  input wire logic REG_REQ,
  input wire logic REG_WE,
  input wire logic [27:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic REG_ACK,
  input wire logic ARR_RD_REQ,
  input wire logic [3:0] ARR_RD_BLOCK,
  input wire logic ARR_RAW_VALID,
  input wire logic [7:0] ARR_RAW_DATA,
  output logic ARR_RD_VALID,
  output logic [7:0] ARR_RD_DATA,
  input wire logic MOD_REQ,
  input wire logic MOD_ERASE,
  input wire logic [3:0] MOD_BLOCK,
  output logic MOD_GO,
  output logic MOD_REJECT,
  input wire logic STAT_CLR,
  output logic [7:0] STAT_BITS,
  input wire logic SUSP_REQ,
  input wire logic OP_ACTIVE,
  input wire logic OP_IS_ERASE,
  input wire logic SAFE_POINT,
  output logic OP_PAUSE
);

  function automatic logic is_lock_addr(input logic [27:0] addr);
    is_lock_addr = (addr & FLK_LOCK_MASK) == FLK_LOCK_BASE;
  endfunction : is_lock_addr

  function automatic logic [3:0] lock_block(input logic [27:0] addr);
    lock_block = addr[FLK_LOCK_BLK_LSB +: 4];
  endfunction : lock_block

  logic soft_rst;
  flk_lock_type lock [FLK_NUM_BLOCKS];
  logic [FLK_NUM_BLOCKS-1:0] lock_wr;
  logic [FLK_NUM_BLOCKS-1:0] write_guarded;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic ack_q;
  logic rd_mask_q;
  logic rd_mask_use;
  logic [7:0] arr_data_q;
  logic arr_valid_q;
  logic go_q;
  logic reject_q;
  logic prot_err_q;
  logic ready_q;
  logic mod_blocked;

  assign soft_rst = !INTERFACE_RESET_PIN_N || !CPU_RESET_PIN_N;

  genvar g;
  generate
    for (g = 0; g < FLK_NUM_BLOCKS; g++) begin : g_lock
      assign lock_wr[g] = REG_REQ && REG_WE && is_lock_addr(REG_ADDR) && (lock_block(REG_ADDR) == 4'(g));
      flk_lock_cell u_cell (
        .clk(CLK),
        .nrst(NRST),
        .soft_rst(soft_rst),
        .wr_en(lock_wr[g]),
        .wdata(REG_WDATA),
        .lock(lock[g])
      );
      // pin guards do not touch the register, only the decision to modify
      if (g == FLK_NUM_BLOCKS - 1) begin : g_top
        assign write_guarded[g] = lock[g].write_prot || !TOP_BLOCK_GUARD_PIN_N;
      end else begin : g_main
        assign write_guarded[g] = lock[g].write_prot || !WRITE_GUARD_PIN_N;
      end
    end
  endgenerate

  // read data; the identifier and snapshot registers have no write path at all
  always_comb begin
    rdata_d = FLK_UNMAPPED_DATA;
    if (is_lock_addr(REG_ADDR)) begin
      rdata_d = {5'h00, lock[lock_block(REG_ADDR)]};
    end else if (REG_ADDR == FLK_GPI_ADDR) begin
      // pins are taken as they are at the request edge, the board keeps them still
      rdata_d = {3'h0, GENERAL_PURPOSE_INPUTS};
    end else if (REG_ADDR == FLK_MAKER_ADDR) begin
      rdata_d = MAKER_CODE;
    end else if (REG_ADDR == FLK_PART_ADDR) begin
      rdata_d = PART_CODE;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_q <= 8'h00;
      ack_q <= 1'b0;
    end else begin
      ack_q <= REG_REQ;
      if (REG_REQ && !REG_WE) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign REG_RDATA = rdata_q;
  assign REG_ACK = ack_q;

  // protection is frozen at the start of the access so a later lock write cannot
  // change a read already under way
  assign rd_mask_use = ARR_RD_REQ ? lock[ARR_RD_BLOCK].read_prot : rd_mask_q;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rd_mask_q <= 1'b0;
    end else if (ARR_RD_REQ) begin
      rd_mask_q <= lock[ARR_RD_BLOCK].read_prot;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      arr_data_q <= 8'h00;
      arr_valid_q <= 1'b0;
    end else begin
      arr_valid_q <= ARR_RAW_VALID;
      if (ARR_RAW_VALID) begin
        arr_data_q <= rd_mask_use ? FLK_READ_LOCKED_DATA : ARR_RAW_DATA;
      end
    end
  end

  assign ARR_RD_VALID = arr_valid_q;
  assign ARR_RD_DATA = arr_data_q;

  assign mod_blocked = write_guarded[MOD_BLOCK];

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      go_q <= 1'b0;
      reject_q <= 1'b0;
    end else begin
      go_q <= MOD_REQ && !mod_blocked;
      reject_q <= MOD_REQ && mod_blocked;
    end
  end

  assign MOD_GO = go_q;
  assign MOD_REJECT = reject_q;

  // a reject in the same cycle as a status clear keeps the error bit set
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      prot_err_q <= 1'b0;
      ready_q <= 1'b0;
    end else if (soft_rst) begin
      prot_err_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      if (MOD_REQ && mod_blocked) begin
        prot_err_q <= 1'b1;
      end else if (STAT_CLR) begin
        prot_err_q <= 1'b0;
      end
      if (MOD_REQ && mod_blocked) begin
        ready_q <= 1'b1;
      end else if (MOD_REQ) begin
        ready_q <= 1'b0;
      end
    end
  end

  always_comb begin
    STAT_BITS = 8'h00;
    STAT_BITS[FLK_STAT_PROT_BIT] = prot_err_q;
    STAT_BITS[FLK_STAT_READY_BIT] = ready_q;
  end

  flk_pause_timer u_pause (
    .clk(CLK),
    .nrst(NRST),
    .susp_req(SUSP_REQ),
    .op_active(OP_ACTIVE),
    .op_is_erase(OP_IS_ERASE),
    .safe_point(SAFE_POINT),
    .pause(OP_PAUSE)
  );

  property p_gpi_read;
    @(posedge CLK) disable iff (!NRST)
    (REG_REQ && !REG_WE && REG_ADDR == FLK_GPI_ADDR) |=> (REG_RDATA == {3'h0, $past(GENERAL_PURPOSE_INPUTS)});
  endproperty
  a_gpi_read: assert property (p_gpi_read) else $error("snapshot read does not match pins");

  property p_maker_read;
    @(posedge CLK) disable iff (!NRST)
    (REG_REQ && !REG_WE && REG_ADDR == FLK_MAKER_ADDR) |=> (REG_RDATA == MAKER_CODE && REG_ACK);
  endproperty
  a_maker_read: assert property (p_maker_read) else $error("maker identifier wrong");

  property p_part_read;
    @(posedge CLK) disable iff (!NRST)
    (REG_REQ && !REG_WE && REG_ADDR == FLK_PART_ADDR) |=> (REG_RDATA == PART_CODE && REG_ACK);
  endproperty
  a_part_read: assert property (p_part_read) else $error("part identifier wrong");

  property p_lock_reserved;
    @(posedge CLK) disable iff (!NRST)
    (REG_REQ && !REG_WE && is_lock_addr(REG_ADDR)) |=> (REG_RDATA[7:3] == 5'h00);
  endproperty
  a_lock_reserved: assert property (p_lock_reserved) else $error("reserved lock bits not zero");

  property p_read_locked;
    @(posedge CLK) disable iff (!NRST)
    (ARR_RAW_VALID && rd_mask_use) |=> (ARR_RD_VALID && ARR_RD_DATA == FLK_READ_LOCKED_DATA);
  endproperty
  a_read_locked: assert property (p_read_locked) else $error("protected read leaked data");

  property p_read_open;
    @(posedge CLK) disable iff (!NRST)
    (ARR_RD_REQ && !lock[ARR_RD_BLOCK].read_prot) ##1 (!ARR_RD_REQ && ARR_RAW_VALID)[*1]
      |=> (ARR_RD_DATA == $past(ARR_RAW_DATA));
  endproperty
  a_read_open: assert property (p_read_open) else $error("open read altered data");

  property p_reject;
    @(posedge CLK) disable iff (!NRST)
    (MOD_REQ && write_guarded[MOD_BLOCK]) |=> (MOD_REJECT && !MOD_GO) ##0 (STAT_BITS[FLK_STAT_PROT_BIT] || soft_rst);
  endproperty
  a_reject: assert property (p_reject) else $error("protected modify not rejected");

  property p_top_pin;
    @(posedge CLK) disable iff (!NRST)
    (MOD_REQ && MOD_BLOCK == FLK_TOP_BLOCK && !TOP_BLOCK_GUARD_PIN_N) |=> MOD_REJECT;
  endproperty
  a_top_pin: assert property (p_top_pin) else $error("top guard pin ignored");

  property p_go;
    @(posedge CLK) disable iff (!NRST)
    (MOD_REQ && !lock[MOD_BLOCK].write_prot && MOD_BLOCK != FLK_TOP_BLOCK && WRITE_GUARD_PIN_N) |=> MOD_GO;
  endproperty
  a_go: assert property (p_go) else $error("unprotected modify refused");

  property p_read_valid;
    @(posedge CLK) disable iff (!NRST)
    ARR_RAW_VALID |=> ARR_RD_VALID;
  endproperty
  a_read_valid: assert property (p_read_valid) else $error("array byte not handed on");

  property p_main_pin;
    @(posedge CLK) disable iff (!NRST)
    (MOD_REQ && MOD_BLOCK != FLK_TOP_BLOCK && !WRITE_GUARD_PIN_N) |=> (MOD_REJECT && !MOD_GO);
  endproperty
  a_main_pin: assert property (p_main_pin) else $error("write guard pin ignored");

  property p_err_sticky;
    @(posedge CLK) disable iff (!NRST)
    (STAT_BITS[FLK_STAT_PROT_BIT] && !STAT_CLR && !soft_rst) |=> STAT_BITS[FLK_STAT_PROT_BIT];
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("protection error bit lost");

  property p_err_clear;
    @(posedge CLK) disable iff (!NRST)
    (STAT_CLR && !MOD_REQ) |=> !STAT_BITS[FLK_STAT_PROT_BIT];
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("status clear ignored");

  c_reject_seen: cover property (@(posedge CLK) disable iff (!NRST) MOD_REJECT);
  c_locked_read: cover property (@(posedge CLK) disable iff (!NRST) ARR_RD_VALID && rd_mask_q);

endmodule : flk_regs
`default_nettype wire

// ==== flk_array_model.sv ====
// Purpose: stand-in for the flash array answering read requests of any block
// Assumes: one read outstanding; latency 1..15 cycles set by the bench
// Notes: data lines carry a toggling pattern whenever no valid byte is offered
`timescale 1ns/1ps
`default_nettype none
module flk_array_model
  import flk_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic rd_req,
  input wire logic [3:0] rd_block,
  input wire logic [3:0] latency,
  output logic raw_valid,
  output logic [7:0] raw_data
);
  logic [3:0] cnt_q;
  logic [3:0] blk_q;
  logic [7:0] noise_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 4'h0;
      blk_q <= 4'h0;
    end else if (rd_req) begin
      cnt_q <= latency;
      blk_q <= rd_block;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  // stale data must never look like a good byte
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      noise_q <= 8'h3c;
    end else begin
      noise_q <= ~noise_q;
    end
  end

  assign raw_valid = (cnt_q == 4'h1);
  assign raw_data = raw_valid ? {blk_q, ~blk_q} : noise_q;
endmodule : flk_array_model
`default_nettype wire

// ==== flk_regs_bench.sv ====
// Purpose: self-checking bench of the lock, input snapshot and identifier registers
// Assumes: inputs change on the falling edge; array stand-in answers reads
// Notes: identifier codes handed to the design are arbitrary values
`timescale 1ns/1ps
`default_nettype none
module flk_regs_bench
  import flk_pkg::*;
;
  localparam logic [7:0] MK = 8'h3c;
  localparam logic [7:0] PT = 8'hc3;
  typedef struct packed {
    logic we;
    logic [27:0] a;
    logic [7:0] d;
    logic [4:0] gpi;
    logic [7:0] e;
  } flk_row_type;
  flk_row_type rows [16] = '{
    '{1'b0, FLK_MAKER_ADDR, 8'h00, 5'h00, MK}, '{1'b1, FLK_MAKER_ADDR, 8'hff, 5'h00, 8'h00},
    '{1'b0, FLK_MAKER_ADDR, 8'h00, 5'h00, MK}, '{1'b0, FLK_PART_ADDR, 8'h00, 5'h00, PT},
    '{1'b1, FLK_PART_ADDR, 8'h00, 5'h00, 8'h00}, '{1'b0, FLK_PART_ADDR, 8'h00, 5'h00, PT},
    '{1'b0, FLK_GPI_ADDR, 8'h00, 5'h01, 8'h01}, '{1'b0, FLK_GPI_ADDR, 8'h00, 5'h02, 8'h02},
    '{1'b0, FLK_GPI_ADDR, 8'h00, 5'h04, 8'h04}, '{1'b0, FLK_GPI_ADDR, 8'h00, 5'h08, 8'h08},
    '{1'b0, FLK_GPI_ADDR, 8'h00, 5'h10, 8'h10}, '{1'b1, FLK_GPI_ADDR, 8'hff, 5'h0a, 8'h00},
    '{1'b0, FLK_GPI_ADDR, 8'h00, 5'h1f, 8'h1f}, '{1'b0, 28'hfbc0200, 8'h00, 5'h00, 8'h00},
    '{1'b1, FLK_LOCK_BASE | 28'h0030000, 8'hfc, 5'h00, 8'h00},
    '{1'b0, FLK_LOCK_BASE | 28'h0030000, 8'h00, 5'h00, 8'h04}};
  logic CLK, NRST, IRST_N, CRST_N, TG_N, WG_N, REG_REQ, REG_WE, REG_ACK;
  logic [4:0] GPI;
  logic [27:0] REG_ADDR;
  logic [7:0] REG_WDATA, REG_RDATA, RAW_D, RD_D, STAT;
  logic RD_REQ, RAW_V, RD_V, MOD_REQ, MOD_ERASE, GO, REJ, STAT_CLR;
  logic [3:0] RD_BLK, MOD_BLK, dly;
  logic SUSP, OP_ACT, OP_ER, SAFE, PAUSE;
  int miscompares = 0;
  int total_checks = 0;
  logic [7:0] q;

  flk_regs #(.MAKER_CODE(MK), .PART_CODE(PT)) dut (.CLK(CLK), .NRST(NRST),
    .INTERFACE_RESET_PIN_N(IRST_N), .CPU_RESET_PIN_N(CRST_N), .GENERAL_PURPOSE_INPUTS(GPI),
    .TOP_BLOCK_GUARD_PIN_N(TG_N), .WRITE_GUARD_PIN_N(WG_N), .REG_REQ(REG_REQ), .REG_WE(REG_WE),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK),
    .ARR_RD_REQ(RD_REQ), .ARR_RD_BLOCK(RD_BLK), .ARR_RAW_VALID(RAW_V), .ARR_RAW_DATA(RAW_D),
    .ARR_RD_VALID(RD_V), .ARR_RD_DATA(RD_D), .MOD_REQ(MOD_REQ), .MOD_ERASE(MOD_ERASE),
    .MOD_BLOCK(MOD_BLK), .MOD_GO(GO), .MOD_REJECT(REJ), .STAT_CLR(STAT_CLR), .STAT_BITS(STAT),
    .SUSP_REQ(SUSP), .OP_ACTIVE(OP_ACT), .OP_IS_ERASE(OP_ER), .SAFE_POINT(SAFE), .OP_PAUSE(PAUSE));
  flk_array_model arr_model (.clk(CLK), .nrst(NRST), .rd_req(RD_REQ), .rd_block(RD_BLK),
    .latency(dly), .raw_valid(RAW_V), .raw_data(RAW_D));

  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  function automatic logic [27:0] la(input logic [3:0] b);
    return FLK_LOCK_BASE | (28'(b) << FLK_LOCK_BLK_LSB);
  endfunction : la

  task automatic cmp(input string nm, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp

  task automatic reg_acc(input logic we, input logic [27:0] a, input logic [7:0] d);
    int n;
    REG_REQ = 1'b1;
    REG_WE = we;
    REG_ADDR = a;
    REG_WDATA = d;
    @(negedge CLK);
    REG_REQ = 1'b0;
    n = 0;
    while (REG_ACK !== 1'b1 && n < 3) begin
      @(negedge CLK);
      n++;
    end
    cmp("ack", 8'(REG_ACK), 8'h01);
    q = REG_RDATA;
    // idle cycle so a following request never meets a strobe lowered in the same step
    @(negedge CLK);
  endtask : reg_acc

  task automatic rd(input logic [27:0] a, input logic [7:0] e);
    reg_acc(1'b0, a, 8'h00);
    cmp("rdata", q, e);
  endtask : rd

  task automatic arr_rd(input logic [3:0] b, input logic [7:0] e);
    int n;
    RD_REQ = 1'b1;
    RD_BLK = b;
    @(negedge CLK);
    RD_REQ = 1'b0;
    n = 0;
    while (RD_V !== 1'b1 && n < 20) begin
      @(negedge CLK);
      n++;
    end
    cmp("array", RD_D, e);
    @(negedge CLK);
  endtask : arr_rd

  task automatic mod(input logic [3:0] b, input logic [1:0] gr, input logic [7:0] st);
    int n;
    MOD_REQ = 1'b1;
    MOD_BLK = b;
    MOD_ERASE = b[0];
    @(negedge CLK);
    MOD_REQ = 1'b0;
    n = 0;
    while (GO !== 1'b1 && REJ !== 1'b1 && n < 3) begin
      @(negedge CLK);
      n++;
    end
    cmp("go_reject", {6'h0, GO, REJ}, {6'h0, gr});
    cmp("status", STAT, st);
    @(negedge CLK);
  endtask : mod

  task automatic susp(input logic er, input int sp, input int lim);
    int n;
    OP_ACT = 1'b1;
    OP_ER = er;
    SUSP = 1'b1;
    @(negedge CLK);
    SUSP = 1'b0;
    n = 1;
    // the pause is combinational and lasts until the next edge, so it is read just after the safe point is set
    while (PAUSE !== 1'b1 && n < 700) begin
      @(negedge CLK);
      n++;
      if (n == sp) SAFE = 1'b1;
      #1;
    end
    cmp("pause_in_time", 8'(n <= lim), 8'h01);
    @(negedge CLK);
    SAFE = 1'b0;
    OP_ACT = 1'b0;
    @(negedge CLK);
  endtask : susp

  task automatic pin_pulse(input logic cpu);
    if (cpu) CRST_N = 1'b0;
    else IRST_N = 1'b0;
    @(negedge CLK);
    CRST_N = 1'b1;
    IRST_N = 1'b1;
  endtask : pin_pulse

  task automatic close_out;
    if (miscompares == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (6000) @(posedge CLK);
    miscompares++;
    close_out();
  end

  initial begin
    {NRST, REG_REQ, REG_WE, REG_ADDR, REG_WDATA, GPI, RD_REQ, RD_BLK, MOD_REQ} = '0;
    {MOD_ERASE, MOD_BLK, STAT_CLR, SUSP, OP_ACT, OP_ER, SAFE} = '0;
    {IRST_N, CRST_N, TG_N, WG_N} = 4'hf;
    dly = 4'h1;
    repeat (5) @(negedge CLK);
    NRST = 1'b1;
    for (int b = 0; b < 16; b++) rd(la(4'(b)), 8'({5'h0, FLK_LOCK_RESET}));
    // pins stay put across each whole read cycle
    foreach (rows[i]) begin
      GPI = rows[i].gpi;
      reg_acc(rows[i].we, rows[i].a, rows[i].d);
      if (!rows[i].we) cmp("table", q, rows[i].e);
    end
    arr_rd(4'h3, FLK_READ_LOCKED_DATA);
    arr_rd(4'h4, 8'h4b);
    dly = 4'h6;
    fork
      arr_rd(4'h5, 8'h5a);
      begin
        @(negedge CLK);
        reg_acc(1'b1, la(4'h5), 8'h04);
      end
    join
    arr_rd(4'h5, 8'h00);
    reg_acc(1'b1, la(4'h6), 8'h02);
    reg_acc(1'b1, la(4'h6), 8'h05);
    rd(la(4'h6), 8'h02);
    reg_acc(1'b1, la(4'h6), 8'h00);
    rd(la(4'h6), 8'h02);
    mod(4'h6, 2'b10, 8'h00);
    mod(4'h7, 2'b01, 8'h82);
    STAT_CLR = 1'b1;
    @(negedge CLK);
    STAT_CLR = 1'b0;
    @(negedge CLK);
    cmp("status_clr", STAT, 8'h80);
    mod(4'h6, 2'b10, 8'h00);
    reg_acc(1'b1, la(4'hf), 8'h00);
    TG_N = 1'b0;
    mod(4'hf, 2'b01, 8'h82);
    TG_N = 1'b1;
    WG_N = 1'b0;
    mod(4'hf, 2'b10, 8'h02);
    mod(4'h6, 2'b01, 8'h82);
    WG_N = 1'b1;
    pin_pulse(1'b0);
    rd(la(4'h6), 8'h01);
    rd(la(4'hf), 8'h01);
    cmp("status_pin", STAT, 8'h00);
    arr_rd(4'h5, 8'h5a);
    reg_acc(1'b1, la(4'h9), 8'h02);
    pin_pulse(1'b1);
    rd(la(4'h9), 8'h01);
    susp(1'b0, 0, 100);
    susp(1'b1, 0, 600);
    susp(1'b1, 5, 7);
    reg_acc(1'b1, la(4'h2), 8'h06);
    NRST = 1'b0;
    repeat (2) @(negedge CLK);
    NRST = 1'b1;
    rd(la(4'h2), 8'h01);
    close_out();
  end
endmodule : flk_regs_bench
`default_nettype wire
